// ===== hdl/slc_line_ctrl.sv
// Two-channel line state controller with an Avalon-MM register slave.
// Assumes fault, ground key and ringing level pins are asynchronous.
// Overview of operation
// (R1) Seventeen states: nine bases plus reversed variants.
// (R2) Every state except off may be reversed.
// (R3) Reset leaves every channel off.
// (R4) Off: voice, regulator and signaling all disabled.
// (R5) Battery overvoltage or clock fault forces off.
// (R6) Device or line init ends in open circuit.
// (R7) Device init resets all and applies parameters.
// (R8) Open circuit: outputs high impedance, regulator floor.
// (R9) Open circuit voice only for diagnostic measurement.
// (R10) Host picks normal or low-power termination.
// (R11) Normal idle: feed, hook supervision, no voice.
// (R12) Low-power idle: ring lead only, monitor line.
// (R13) Onhook transmit: feed, voice, hook, caller ID.
// (R14) Fed and conversation feed; PCM only conversation.
// (R15) Fed and conversation allow type 2 caller ID.
// (R16) Tip float raises ground start on key current.
// (R17) Ringing uses the higher ringing current limit.
// (R18) Ring generator starts, applies at level match.
// (R19) Ring entry completes within one ring period.
// (R20) Ring exit waits for next state's level.
// (R21) Ring entry and exit sync are configurable.
// (R22) Ringing regulator mode tracking or fixed.
// (R23) Loud tone: no transmit, no synthesis, gain boost.
// (R24) State register changes on request or fault.
//
// Our own choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
module slc_line_ctrl #(
  parameter int RING_PERIOD_DEF = slc_pkg::RING_PERIOD_CYC
) (
  input  wire logic                         sys_clk,
  input  wire logic                         rst,
  input  wire logic [5:0]                   avs_address,
  input  wire logic                         avs_read,
  input  wire logic                         avs_write,
  input  wire logic [31:0]                  avs_writedata,
  output logic      [31:0]                  avs_readdata,
  output logic                              avs_waitrequest,
  input  wire logic                         battery_overvoltage,
  input  wire logic                         clock_fault,
  input  wire logic [slc_pkg::NCH-1:0]      gnd_key_over,
  input  wire logic [slc_pkg::NCH-1:0]      ring_level_match,
  input  wire logic [slc_pkg::NCH-1:0]      ring_trip,
  output slc_pkg::slc_ctrl_t [slc_pkg::NCH-1:0] line_ctrl
);

  localparam int NCH = slc_pkg::NCH;

  // Two-stage synchronisers; logic uses the second stage, plus gk_d, a delayed gk_s2 for the ground key edge.
  logic [1:0]     flt_s1;
  logic [1:0]     flt_s2;
  logic [NCH-1:0] gk_s1;
  logic [NCH-1:0] gk_s2;
  logic [NCH-1:0] gk_d;
  logic [NCH-1:0] rm_s1;
  logic [NCH-1:0] rm_s2;
  logic [NCH-1:0] rt_s1;
  logic [NCH-1:0] rt_s2;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      flt_s1 <= '0;
      flt_s2 <= '0;
      gk_s1  <= '0;
      gk_s2  <= '0;
      gk_d   <= '0;
      rm_s1  <= '0;
      rm_s2  <= '0;
      rt_s1  <= '0;
      rt_s2  <= '0;
    end else begin
      flt_s1 <= {clock_fault, battery_overvoltage};
      flt_s2 <= flt_s1;
      gk_s1  <= gnd_key_over;
      gk_s2  <= gk_s1;
      gk_d   <= gk_s2;
      rm_s1  <= ring_level_match;
      rm_s2  <= rm_s1;
      rt_s1  <= ring_trip;
      rt_s2  <= rt_s1;
    end
  end

  logic fault_any;
  assign fault_any = |flt_s2;

  // Bus slave: every access is answered one cycle after it is seen.
  logic bus_take;
  logic wr_take;
  assign bus_take = (avs_read | avs_write) & ~avs_waitrequest;
  assign wr_take  = avs_write & ~avs_waitrequest;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else if (bus_take) begin
      avs_waitrequest <= 1'b1;
    end else if (avs_read | avs_write) begin
      avs_waitrequest <= 1'b0;
    end
  end

  logic           dev_init;
  logic [NCH-1:0] line_init;
  assign dev_init = wr_take && avs_address == slc_pkg::OFS_INIT
                    && avs_writedata[slc_pkg::INIT_DEVICE];

  function automatic logic ch_hit(input logic [5:0] addr, input int ch,
                                  input logic [3:0] ofs);
    ch_hit = addr[5:4] == 2'(ch) && addr[3:0] == ofs;
  endfunction

  function automatic logic valid_req(input logic [4:0] code);
    valid_req = code[3:0] <= 4'(slc_pkg::line_state_loud_tone)
                && !(code[4] && code[3:0] == 4'h0); // R1 R2
  endfunction

  // Drives the front-end enables from the state and its configuration.
  function automatic slc_pkg::slc_ctrl_t decode(
    input slc_pkg::slc_line_t ls,
    input slc_pkg::slc_cfg_t  cfg,
    input slc_pkg::slc_ring_t rp
  );
    slc_pkg::slc_ctrl_t c;
    c = slc_pkg::CTRL_RST;
    c.polarity_rev = ls.rev; // R2
    c.reg_mode     = slc_pkg::REG_TRACK;
    c.tx_path_en   = 1'b1;
    c.zsynth_en    = 1'b1;
    case (ls.base)
      slc_pkg::line_state_off: begin
        c = slc_pkg::CTRL_RST; // R4
      end
      slc_pkg::line_state_open_circuit: begin
        c.line_hiz = 1'b1; // R8
        c.reg_mode = slc_pkg::REG_FLOOR; // R8
        c.voice_en = cfg.diag_measure; // R9
      end
      slc_pkg::line_state_idle_onhook: begin
        if (cfg.termination_type == slc_pkg::termination_low_power) begin
          c.ring_only      = 1'b1; // R12
          c.low_power_idle = 1'b1; // R12
          c.hook_sup_en    = 1'b1; // R12
        end else begin
          c.feed_en     = 1'b1; // R11
          c.hook_sup_en = 1'b1; // R11
        end
      end
      slc_pkg::line_state_tip_float: begin
        c.tip_hiz     = 1'b1;
        c.hook_sup_en = 1'b1;
      end
      slc_pkg::line_state_onhook_transmit: begin
        c.feed_en     = 1'b1; // R13
        c.voice_en    = 1'b1; // R13
        c.hook_sup_en = 1'b1; // R13
        c.cid_en      = 1'b1; // R13
      end
      slc_pkg::line_state_fed, slc_pkg::line_state_conversation: begin
        c.feed_en      = 1'b1; // R14
        c.hook_sup_en  = 1'b1; // R14
        c.voice_en     = 1'b1;
        c.cid_type2_en = 1'b1; // R15
        c.pcm_en = ls.base == slc_pkg::line_state_conversation; // R14
      end
      slc_pkg::line_state_ring: begin
        c.hook_sup_en = 1'b1;
        c.voice_en    = 1'b1;
        c.ring_gen_en = 1'b1; // R18
        c.ring_apply  = rp == slc_pkg::RP_ON || rp == slc_pkg::RP_EXIT;
        c.ringing_current_limit = c.ring_apply; // R17
        c.reg_mode = cfg.ring_reg_fixed ? slc_pkg::REG_FIXED
                                        : slc_pkg::REG_TRACK; // R22
        if (!c.ring_apply) begin
          c.feed_en = 1'b1;
        end
      end
      slc_pkg::line_state_loud_tone: begin
        c.feed_en       = 1'b1;
        c.hook_sup_en   = 1'b1;
        c.voice_en      = 1'b1;
        c.tx_path_en    = 1'b0; // R23
        c.zsynth_en     = 1'b0; // R23
        c.rx_gain_boost = slc_pkg::HOWLER_BOOST_TENTH_DB; // R23
      end
      default: begin
        c = slc_pkg::CTRL_RST;
      end
    endcase
    if (ls.base != slc_pkg::line_state_ring) begin
      c.ring_gen_en = 1'b0;
    end
    decode = c;
  endfunction

  slc_pkg::slc_line_t [NCH-1:0] cur_state;
  slc_pkg::slc_cfg_t  [NCH-1:0] cfg_live;
  slc_pkg::slc_ring_t [NCH-1:0] ring_phase;
  logic [NCH-1:0][23:0]         ring_period;
  logic [NCH-1:0][31:0]         status_word;

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : gen_ch
      slc_pkg::slc_cfg_t  cfg_shadow;
      slc_pkg::slc_line_t pend_state;
      logic               pend_valid;
      logic [23:0]        entry_cnt;
      logic               gnd_start;
      logic               reject;
      logic               req_wr;
      logic               req_ok;
      logic               do_init;
      logic               exit_now;
      logic               gnd_evt;
      logic               gnd_clr;

      assign line_init[g] = wr_take && avs_address == slc_pkg::OFS_INIT
                            && avs_writedata[slc_pkg::INIT_LINE0 + g];
      assign do_init = dev_init | line_init[g];
      assign req_wr  = wr_take && ch_hit(avs_address, g, slc_pkg::OFS_LINE);
      assign req_ok  = req_wr && valid_req(avs_writedata[4:0]);
      assign gnd_evt = cur_state[g].base == slc_pkg::line_state_tip_float
                       && gk_s2[g] && !gk_d[g];
      assign gnd_clr = wr_take
                       && ch_hit(avs_address, g, slc_pkg::OFS_STATUS)
                       && avs_writedata[slc_pkg::ST_GND_START];
      // Without exit sync the ring leaves at once; otherwise at level match.
      assign exit_now = !cfg_live[g].ring_exit_sync || rm_s2[g]; // R20 R21

      // Parameters are staged by software and take effect on init; the ring period applies as soon as it is written.
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          cfg_shadow <= slc_pkg::CFG_RST;
        end else if (wr_take && ch_hit(avs_address, g, slc_pkg::OFS_CFG)) begin
          cfg_shadow <= slc_pkg::slc_cfg_t'(avs_writedata[4:0]);
        end
      end

      always_ff @(posedge sys_clk) begin
        if (rst) begin
          cfg_live[g]    <= slc_pkg::CFG_RST;
          ring_period[g] <= 24'(RING_PERIOD_DEF);
        end else begin
          if (do_init) begin
            cfg_live[g] <= cfg_shadow; // R6 R7 R10
          end
          if (wr_take && ch_hit(avs_address, g, slc_pkg::OFS_PERIOD)) begin
            ring_period[g] <= avs_writedata[23:0];
          end
        end
      end

      // Line state and ring sequencing.
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          cur_state[g]  <= slc_pkg::LINE_RST; // R3
          ring_phase[g] <= slc_pkg::RP_IDLE;
          pend_state    <= slc_pkg::LINE_RST;
          pend_valid    <= 1'b0;
          entry_cnt     <= '0;
        end else if (fault_any) begin
          cur_state[g]  <= slc_pkg::LINE_RST; // R5 R24
          ring_phase[g] <= slc_pkg::RP_IDLE;
          pend_valid    <= 1'b0;
        end else if (do_init) begin
          cur_state[g]  <= '{rev: 1'b0,
                            base: slc_pkg::line_state_open_circuit}; // R6
          ring_phase[g] <= slc_pkg::RP_IDLE;
          pend_valid    <= 1'b0;
        end else begin
          case (ring_phase[g])
            slc_pkg::RP_IDLE: begin
              if (req_ok) begin
                cur_state[g] <= slc_pkg::slc_line_t'(avs_writedata[4:0]); // R24
                if (avs_writedata[3:0] == 4'(slc_pkg::line_state_ring)) begin
                  ring_phase[g] <= cfg_live[g].ring_entry_sync
                                   ? slc_pkg::RP_ENTRY
                                   : slc_pkg::RP_ON; // R18 R21
                  entry_cnt     <= '0;
                end
              end
            end
            slc_pkg::RP_ENTRY: begin
              entry_cnt <= entry_cnt + 24'h000001;
              if (req_ok) begin
                cur_state[g]  <= slc_pkg::slc_line_t'(avs_writedata[4:0]);
                ring_phase[g] <= slc_pkg::RP_IDLE;
              end else if (rm_s2[g]
                           || entry_cnt + 24'h000001 >= ring_period[g]) begin
                ring_phase[g] <= slc_pkg::RP_ON; // R18 R19
              end
            end
            slc_pkg::RP_ON: begin
              if (req_ok) begin
                pend_state    <= slc_pkg::slc_line_t'(avs_writedata[4:0]);
                pend_valid    <= 1'b1;
                ring_phase[g] <= slc_pkg::RP_EXIT; // R20
              end else if (rt_s2[g]) begin
                pend_state    <= '{rev: cur_state[g].rev,
                                  base: slc_pkg::line_state_fed};
                pend_valid    <= 1'b1;
                ring_phase[g] <= slc_pkg::RP_EXIT; // R20
              end
            end
            slc_pkg::RP_EXIT: begin
              if (req_ok) begin
                pend_state <= slc_pkg::slc_line_t'(avs_writedata[4:0]);
              end
              if (exit_now) begin
                cur_state[g]  <= req_ok
                                 ? slc_pkg::slc_line_t'(avs_writedata[4:0])
                                 : pend_state; // R20 R24
                pend_valid    <= 1'b0;
                ring_phase[g] <= slc_pkg::RP_IDLE;
              end
            end
            default: begin
              ring_phase[g] <= slc_pkg::RP_IDLE;
            end
          endcase
        end
      end

      // Sticky flags: a new event outranks a clear in the same cycle.
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          gnd_start <= 1'b0;
          reject    <= 1'b0;
        end else begin
          if (gnd_evt) begin
            gnd_start <= 1'b1; // R16
          end else if (gnd_clr) begin
            gnd_start <= 1'b0;
          end
          if ((req_wr && !req_ok) || (req_wr && fault_any)) begin
            reject <= 1'b1;
          end else if (wr_take
                       && ch_hit(avs_address, g, slc_pkg::OFS_STATUS)
                       && avs_writedata[slc_pkg::ST_REJECT]) begin
            reject <= 1'b0;
          end
        end
      end

      always_ff @(posedge sys_clk) begin
        if (rst) begin
          line_ctrl[g] <= slc_pkg::CTRL_RST; // R3
        end else begin
          line_ctrl[g] <= decode(cur_state[g], cfg_live[g], ring_phase[g]);
        end
      end

      always_comb begin
        status_word[g] = '0;
        status_word[g][4:0] = cur_state[g];
        status_word[g][6:5] = ring_phase[g];
        status_word[g][slc_pkg::ST_GND_START] = gnd_start;
        status_word[g][slc_pkg::ST_REJECT]    = reject;
        status_word[g][slc_pkg::ST_FAULT]     = fault_any;
        status_word[g][slc_pkg::ST_PENDING]   = pend_valid;
      end
    end
  endgenerate

  // Read data is latched in the cycle that drops waitrequest.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      avs_readdata <= '0;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= '0;
      for (int c = 0; c < NCH; c++) begin
        if (ch_hit(avs_address, c, slc_pkg::OFS_LINE)) begin
          avs_readdata <= {27'h0, cur_state[c]};
        end
        if (ch_hit(avs_address, c, slc_pkg::OFS_CFG)) begin
          avs_readdata <= {27'h0, cfg_live[c]};
        end
        if (ch_hit(avs_address, c, slc_pkg::OFS_STATUS)) begin
          avs_readdata <= status_word[c];
        end
        if (ch_hit(avs_address, c, slc_pkg::OFS_PERIOD)) begin
          avs_readdata <= {8'h0, ring_period[c]};
        end
      end
      if (avs_address == slc_pkg::OFS_FAULT) begin
        avs_readdata <= {30'h0, flt_s2};
      end
    end
  end

endmodule

// ===== hdl/slc_pkg.sv
// Constants, register map and types for the two-channel line state control.
// Assumes a 100 MHz system clock and a 32-bit Avalon-MM register bus.
package slc_pkg;

  localparam int NCH = 2;

  localparam int CLK_HZ          = 100_000_000;
  localparam int RING_FREQ_HZ    = 20;
  localparam int RING_PERIOD_CYC = CLK_HZ / RING_FREQ_HZ;

  // Receive gain boost in the loud tone state, in tenths of a dB.
  localparam logic [7:0] HOWLER_BOOST_TENTH_DB = 8'h73;

  // Byte offsets; channel n registers sit at n * CH_STRIDE.
  localparam logic [5:0] CH_STRIDE   = 6'h10;
  localparam logic [3:0] OFS_LINE    = 4'h0;
  localparam logic [3:0] OFS_CFG     = 4'h4;
  localparam logic [3:0] OFS_STATUS  = 4'h8;
  localparam logic [3:0] OFS_PERIOD  = 4'hc;
  localparam logic [5:0] OFS_INIT    = 6'h20;
  localparam logic [5:0] OFS_FAULT   = 6'h24;

  // Status bit positions.
  localparam int ST_GND_START = 8;
  localparam int ST_REJECT    = 9;
  localparam int ST_FAULT     = 10;
  localparam int ST_PENDING   = 11;

  // Init command bit positions.
  localparam int INIT_DEVICE  = 0;
  localparam int INIT_LINE0   = 1;

  typedef enum logic [3:0] {
    line_state_off             = 4'h0,
    line_state_open_circuit    = 4'h1,
    line_state_idle_onhook     = 4'h2,
    line_state_tip_float       = 4'h3,
    line_state_onhook_transmit = 4'h4,
    line_state_fed             = 4'h5,
    line_state_conversation    = 4'h6,
    line_state_ring            = 4'h7,
    line_state_loud_tone       = 4'h8
  } slc_base_t;

  typedef struct packed {
    logic      rev;
    slc_base_t base;
  } slc_line_t;

  localparam slc_line_t LINE_RST = '{rev: 1'b0, base: line_state_off};

  typedef enum logic [1:0] {
    RP_IDLE  = 2'b00,
    RP_ENTRY = 2'b01,
    RP_ON    = 2'b10,
    RP_EXIT  = 2'b11
  } slc_ring_t;

  typedef enum logic [1:0] {
    REG_OFF   = 2'b00,
    REG_FLOOR = 2'b01,
    REG_TRACK = 2'b10,
    REG_FIXED = 2'b11
  } slc_reg_mode_t;

  typedef struct packed {
    logic diag_measure;
    logic ring_reg_fixed;
    logic ring_exit_sync;
    logic ring_entry_sync;
    logic termination_type;
  } slc_cfg_t;

  localparam slc_cfg_t CFG_RST = '0;
  localparam logic termination_normal    = 1'b0;
  localparam logic termination_low_power = 1'b1;

  typedef struct packed {
    logic          feed_en;
    logic          hook_sup_en;
    logic          voice_en;
    logic          pcm_en;
    logic          cid_en;
    logic          cid_type2_en;
    logic          line_hiz;
    logic          tip_hiz;
    logic          ring_only;
    logic          low_power_idle;
    logic          polarity_rev;
    logic          ring_gen_en;
    logic          ring_apply;
    logic          ringing_current_limit;
    logic          tx_path_en;
    logic          zsynth_en;
    slc_reg_mode_t reg_mode;
    logic [7:0]    rx_gain_boost;
  } slc_ctrl_t;

  localparam slc_ctrl_t CTRL_RST = '0;

endpackage

// ===== verif/slc_line_model.sv
// Line front end model: reports when the ringing voltage meets the target.
// Assumes one instance per channel, fed by that channel's control word.
`timescale 1ns/1ps
module slc_line_model #(
  parameter int GAP = 12
) (
  input  wire logic               sys_clk,
  input  wire logic               hold,
  input  wire slc_pkg::slc_ctrl_t ctrl,
  output logic                    level_match
);
  int cnt = 0;
  initial level_match = 1'b0;
  // The ring wave crosses the target once every GAP cycles; hold keeps the
  // crossing away so that the entry timeout can be reached and a sync exit stays pending.
  always @(posedge sys_clk) begin
    if (!ctrl.ring_gen_en)
      cnt <= 0;
    else
      cnt <= (cnt == GAP - 1) ? 0 : cnt + 1;
    level_match <= ctrl.ring_gen_en && !hold && cnt == GAP - 1;
  end
endmodule

// ===== verif/slc_line_props.sv
// Port-level checks for the line state controller.
// Assumes a bind from the bench that hands on the ring period parameter.
`timescale 1ns/1ps
module slc_line_props #(
  parameter int RING_PERIOD_DEF = 50
) (
  input wire logic                                 sys_clk,
  input wire logic                                 rst,
  input wire logic                                 avs_read,
  input wire logic                                 avs_write,
  input wire logic                                 avs_waitrequest,
  input wire logic                                 battery_overvoltage,
  input wire logic                                 clock_fault,
  input wire slc_pkg::slc_ctrl_t [slc_pkg::NCH-1:0] line_ctrl
);
  // Slack of a few cycles covers the input synchronizer and output register.
  localparam int ENTRY_MAX = RING_PERIOD_DEF + 4;
  slc_pkg::slc_ctrl_t c0;
  assign c0 = line_ctrl[0];
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_bus_answer: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered next cycle");
  a_bus_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_fault_off: assert property (
    (battery_overvoltage || clock_fault)[*5] |-> line_ctrl == '0)
    else $error("fault did not force channels off");
  a_hiz_floor: assert property (
    c0.line_hiz |-> c0.reg_mode == slc_pkg::REG_FLOOR && !c0.feed_en)
    else $error("high impedance without regulator floor");
  a_lp_idle: assert property (
    c0.low_power_idle |-> c0.ring_only && !c0.feed_en && !c0.voice_en)
    else $error("low power idle with feed or voice");
  a_pcm_fed: assert property (
    c0.pcm_en |-> c0.feed_en && c0.hook_sup_en && c0.cid_type2_en)
    else $error("pcm enabled without feed");
  a_loud_gain: assert property (
    c0.rx_gain_boost != 8'h00 |->
      c0.rx_gain_boost == slc_pkg::HOWLER_BOOST_TENTH_DB &&
      !c0.tx_path_en && !c0.zsynth_en)
    else $error("gain boost wrong or transmit path on");
  a_ring_limit: assert property (
    c0.ring_apply |-> c0.ring_gen_en && c0.ringing_current_limit)
    else $error("ringing applied without generator or limit");
  a_ring_entry: assert property (
    $rose(c0.ring_gen_en) |->
      ##[0:ENTRY_MAX] (c0.ring_apply || !c0.ring_gen_en))
    else $error("ring entry exceeded one ring period");
  cover property ($rose(c0.ring_apply));
  cover property ($fell(c0.ring_apply));
  cover property (c0.pcm_en);
  cover property (c0.low_power_idle);
endmodule

// ===== verif/testbench.sv
// Self-checking bench for the line state controller over Avalon-MM.
// Assumes the package, controller, checker and line model are compiled first.
`timescale 1ns/1ps
bind slc_line_ctrl slc_line_props #(.RING_PERIOD_DEF(RING_PERIOD_DEF)) u_props (
  .sys_clk(sys_clk), .rst(rst), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .battery_overvoltage(battery_overvoltage),
  .clock_fault(clock_fault), .line_ctrl(line_ctrl));
module testbench;
  localparam int PER = 50;
  localparam logic [5:0] A_CFG = {2'b00, slc_pkg::OFS_CFG};
  localparam logic [5:0] A_ST  = {2'b00, slc_pkg::OFS_STATUS};
  // Per base state: {mask, value} of the flag bits, then reg_mode mask, value.
  localparam logic [35:0] TBL [10] = '{36'hffff0000c, 36'ha2380200d,
    36'he0f8c0000, 36'h013801000, 36'he838e8000, 36'hd438c4000,
    36'hd438d4000, 36'h0, 36'h003b00000, 36'he0f840c00};
  logic                     sys_clk = 1'b0;
  logic                     rst = 1'b1;
  logic [5:0]               avs_address = '0;
  logic                     avs_read = 1'b0;
  logic                     avs_write = 1'b0;
  logic [31:0]              avs_writedata = '0;
  logic [31:0]              avs_readdata;
  logic                     avs_waitrequest;
  logic                     battery_overvoltage = 1'b0;
  logic                     clock_fault = 1'b0;
  logic [1:0]               gnd_key_over = '0;
  wire logic [1:0]          ring_level_match;
  logic [1:0]               ring_trip = '0;
  logic [1:0]               hold = '0;
  slc_pkg::slc_ctrl_t [1:0] line_ctrl;
  int                       failures = 0;
  int                       compares = 0;
  int                       n;
  logic [31:0]              q;
  always #5 sys_clk = ~sys_clk;
  slc_line_ctrl #(.RING_PERIOD_DEF(PER)) dut (.sys_clk(sys_clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .battery_overvoltage(battery_overvoltage), .clock_fault(clock_fault),
    .gnd_key_over(gnd_key_over), .ring_level_match(ring_level_match),
    .ring_trip(ring_trip), .line_ctrl(line_ctrl));
  slc_line_model u_m0 (.sys_clk(sys_clk), .hold(hold[0]),
    .ctrl(line_ctrl[0]), .level_match(ring_level_match[0]));
  slc_line_model u_m1 (.sys_clk(sys_clk), .hold(hold[1]),
    .ctrl(line_ctrl[1]), .level_match(ring_level_match[1]));
  task automatic conclude();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // Holds the request until waitrequest is seen low, then drops it.
  task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge sys_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 40);
    if (k >= 40)
      chk(32'(k), 32'h0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic ctl(input logic [3:0] b, input logic r, input logic lp);
    logic [35:0] t;
    logic [25:0] m;
    logic [25:0] v;
    t = TBL[(b == 4'h2 && lp) ? 9 : b];
    m = {t[35:20], t[3:2], 8'hff};
    v = {t[19:4] | {10'h0, r, 5'h0}, t[1:0],
         (b == 4'h8) ? slc_pkg::HOWLER_BOOST_TENTH_DB : 8'h00};
    repeat (3) @(posedge sys_clk);
    #1;
    chk(32'(line_ctrl[0] & m), 32'(v));
    acc(1'b0, A_ST, 32'h0);
    chk(32'(q[4:0]), {27'h0, r, b});
  endtask
  task automatic waitap(input logic v);
    n = 0;
    #1;
    while (line_ctrl[0].ring_apply !== v && n < 1000) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
  endtask
  task automatic ring(input logic [31:0] cfg, input logic h, input int lo,
                      input int hi, input logic [1:0] rm);
    acc(1'b1, A_CFG, cfg);
    acc(1'b1, slc_pkg::OFS_INIT, 32'h2);
    hold[0] <= h;
    acc(1'b1, 6'h00, 32'h7);
    waitap(1'b1);
    chk({31'h0, n >= lo && n <= hi}, 32'h1);
    chk(32'({line_ctrl[0].ringing_current_limit, line_ctrl[0].ring_gen_en}),
        32'h3);
    chk(32'(line_ctrl[0].reg_mode), 32'(rm));
  endtask
  initial begin
    #200_000;
    failures++;
    conclude();
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    #1;
    chk({30'h0, line_ctrl !== '0, avs_waitrequest}, 32'h1);
    @(posedge sys_clk);
    rst <= 1'b0;
    ctl(4'h0, 1'b0, 1'b0);
    acc(1'b0, 6'h30, 32'h0);
    chk(q, 32'h0);
    acc(1'b1, slc_pkg::OFS_INIT, 32'h1);
    ctl(4'h1, 1'b0, 1'b0);
    acc(1'b0, 6'h10, 32'h0);
    chk(q, 32'h1);
    chk(32'(line_ctrl[1].line_hiz), 32'h1);
    for (int r = 0; r < 2; r++)
      for (int b = 1; b < 9; b++)
        if (b != 7) begin
          acc(1'b1, 6'h00, {27'h0, 1'(r), 4'(b)});
          ctl(4'(b), 1'(r), 1'b0);
        end
    foreach (TBL[i])
      if (i < 2) begin
        acc(1'b1, A_ST, 32'h200);
        acc(1'b1, 6'h00, (i == 0) ? 32'h10 : 32'h9);
        acc(1'b0, A_ST, 32'h0);
        chk(q & 32'h21f, 32'h218);
      end
    acc(1'b1, A_CFG, 32'h1);
    acc(1'b1, 6'h00, 32'h2);
    ctl(4'h2, 1'b0, 1'b0);
    acc(1'b1, slc_pkg::OFS_INIT, 32'h2);
    ctl(4'h1, 1'b0, 1'b0);
    acc(1'b1, 6'h00, 32'h2);
    ctl(4'h2, 1'b0, 1'b1);
    for (int s = 5; s >= 3; s -= 2) begin
      acc(1'b1, 6'h00, 32'(s));
      acc(1'b1, A_ST, 32'h100);
      gnd_key_over[0] <= 1'b1;
      repeat (6) @(posedge sys_clk);
      gnd_key_over[0] <= 1'b0;
      acc(1'b0, A_ST, 32'h0);
      chk(32'(q[8]), 32'(s == 3));
    end
    acc(1'b1, A_CFG, 32'h10);
    acc(1'b1, slc_pkg::OFS_INIT, 32'h2);
    repeat (2) @(posedge sys_clk);
    #1;
    chk(32'({line_ctrl[0].line_hiz, line_ctrl[0].voice_en}), 32'h3);
    ring(32'h6, 1'b1, PER - 5, PER + 5, slc_pkg::REG_TRACK);
    acc(1'b1, 6'h00, 32'h6);
    repeat (4) @(posedge sys_clk);
    #1;
    chk(32'(line_ctrl[0].ring_apply), 32'h1);
    acc(1'b0, A_ST, 32'h0);
    chk(q & 32'h860, 32'h860);
    hold[0] <= 1'b0;
    waitap(1'b0);
    ctl(4'h6, 1'b0, 1'b0);
    ring(32'h6, 1'b0, 10, PER - 10, slc_pkg::REG_TRACK);
    ring(32'h8, 1'b1, 0, 4, slc_pkg::REG_FIXED);
    @(posedge sys_clk);
    ring_trip[0] <= 1'b1;
    repeat (4) @(posedge sys_clk);
    ring_trip[0] <= 1'b0;
    ctl(4'h5, 1'b0, 1'b0);
    for (int f = 0; f < 2; f++) begin
      acc(1'b1, 6'h00, 32'h5);
      battery_overvoltage <= (f == 0);
      clock_fault <= (f == 1);
      repeat (6) @(posedge sys_clk);
      acc(1'b1, 6'h00, 32'h6);
      acc(1'b0, slc_pkg::OFS_FAULT, 32'h0);
      chk(q, 32'(f + 1));
      acc(1'b0, A_ST, 32'h0);
      chk(q & 32'h61f, 32'h600);
      battery_overvoltage <= 1'b0;
      clock_fault <= 1'b0;
      repeat (4) @(posedge sys_clk);
      acc(1'b1, A_ST, 32'h200);
      ctl(4'h0, 1'b0, 1'b0);
    end
    conclude();
  end
endmodule
